// *** logic/sram_ctrl.sv ***
`timescale 1ns/1ns
`include "sram_ctrl_cfg.svh"

// Notes on behaviour
// - Write strobe stays high throughout every read cycle.
// - Write happens only while select and strobe are both low.
// - Read cycle lasts at least the minimum cycle time.
// - Write cycle lasts at least the minimum cycle time.
// - Index stays stable long enough before the write ends.
// - Select stays low long enough before a select-ended write ends.

module sram_ctrl #(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int DATA_W = `DATA_BITS
) (
  // Clock, reset, enable
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // User request
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rd_valid_o,
  output logic      [DATA_W-1:0] rd_data_o,
  // Memory pins
  output logic      [ADDR_W-1:0] word_index_o,
  output logic                   select_n_o,
  output logic                   write_n_o,
  input  wire logic [DATA_W-1:0] shared_data_pins_i,
  output logic      [DATA_W-1:0] shared_data_pins_o,
  output logic                   shared_data_pins_oe_n_o
);

  localparam int CYCLE_CYC  = `CYCLE_CYC;
  localparam int STROBE_CYC = `STROBE_CYC;
  localparam int ADDR_CYC   = `ADDR_END_CYC;
  localparam int ACCESS_CYC = `ACCESS_CYC;
  localparam int FLOAT_CYC  = `FLOAT_CYC;
  localparam int SFLT_CYC   = `STROBE_FLOAT_CYC;
  // A pin value reaches the sync output three edges after it is
  // sampled and is captured one edge later: wait access plus four
  localparam int SYNC_LAT   = 2;
  localparam int RD_WAIT    = ACCESS_CYC + SYNC_LAT + 2;
  localparam int CNT_W      = 4;

  initial begin
    if (ADDR_W != `ADDR_BITS || DATA_W != `DATA_BITS) begin
      $error("sram_ctrl: widths must match the memory organisation");
    end
    if (RD_WAIT >= (1 << CNT_W) || CYCLE_CYC >= (1 << CNT_W)) begin
      $error("sram_ctrl: timing counts exceed counter width");
    end
  end

  // ----------------------------------------------------------
  // Returns the wait count, as counter width, for a phase
  // ----------------------------------------------------------
  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n - 1);
  endfunction

  sram_ctrl_pkg::ctrl_state_t state_r;
  logic [CNT_W-1:0]           cnt_r;
  logic [DATA_W-1:0]          pins_sync;

  pin_sync #(
    .WIDTH (DATA_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .async_i    (shared_data_pins_i),
    .sync_o     (pins_sync)
  );

  wire logic cnt_done = (cnt_r == '0);

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= sram_ctrl_pkg::ST_IDLE;
      cnt_r   <= '0;
    end else if (ce_i) begin
      case (state_r)
        sram_ctrl_pkg::ST_IDLE: begin
          if (req_valid_i && req_write_i) begin
            state_r <= sram_ctrl_pkg::ST_WR_FLOAT;
            cnt_r   <= cnt_of(SFLT_CYC);
          end else if (req_valid_i) begin
            state_r <= sram_ctrl_pkg::ST_READ;
            cnt_r   <= cnt_of(RD_WAIT);
          end
        end
        sram_ctrl_pkg::ST_READ: begin
          if (cnt_done) begin
            state_r <= sram_ctrl_pkg::ST_TURN;
            cnt_r   <= cnt_of(FLOAT_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WR_FLOAT: begin
          if (cnt_done) begin
            state_r <= sram_ctrl_pkg::ST_WR_STROBE;
            cnt_r   <= cnt_of(STROBE_CYC > ADDR_CYC ?
                              STROBE_CYC : ADDR_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WR_STROBE: begin
          if (cnt_done) begin
            state_r <= sram_ctrl_pkg::ST_WR_TAIL;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WR_TAIL: begin
          // Select and strobe rise together, so memory stays floated
          state_r <= sram_ctrl_pkg::ST_TURN;
          cnt_r   <= cnt_of(FLOAT_CYC);
        end
        sram_ctrl_pkg::ST_TURN: begin
          if (cnt_done) begin
            state_r <= sram_ctrl_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= sram_ctrl_pkg::ST_IDLE;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Memory pins
  // ----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      word_index_o            <= '0;
      select_n_o              <= 1'b1;
      write_n_o               <= 1'b1;
      shared_data_pins_o      <= '0;
      shared_data_pins_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      case (state_r)
        sram_ctrl_pkg::ST_IDLE: begin
          if (req_valid_i) begin
            // Index held from here to the end of the cycle
            word_index_o <= req_addr_i;
            select_n_o   <= 1'b0;
            // Strobe falls with select on a write: memory never drives
            write_n_o    <= !req_write_i;
            shared_data_pins_o <= req_wdata_i;
          end
        end
        sram_ctrl_pkg::ST_WR_FLOAT: begin
          if (cnt_done) begin
            shared_data_pins_oe_n_o <= 1'b0;
          end
        end
        sram_ctrl_pkg::ST_WR_STROBE: begin
          if (cnt_done) begin
            // End write while data still driven, keeps hold time
            select_n_o <= 1'b1;
            write_n_o  <= 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WR_TAIL: begin
          shared_data_pins_oe_n_o <= 1'b1;
        end
        sram_ctrl_pkg::ST_READ: begin
          if (cnt_done) begin
            select_n_o <= 1'b1;
          end
        end
        default: begin
          select_n_o              <= 1'b1;
          write_n_o               <= 1'b1;
          shared_data_pins_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // User side answers
  // ----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      req_ready_o <= 1'b1;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= '0;
    end else if (ce_i) begin
      rd_valid_o <= 1'b0;
      if (state_r == sram_ctrl_pkg::ST_IDLE && req_valid_i) begin
        req_ready_o <= 1'b0;
      end else if (state_r == sram_ctrl_pkg::ST_TURN && cnt_done) begin
        req_ready_o <= 1'b1;
      end
      if (state_r == sram_ctrl_pkg::ST_READ && cnt_done) begin
        rd_valid_o <= 1'b1;
        rd_data_o  <= pins_sync;
      end
    end
  end

endmodule // sram_ctrl

// *** include/sram_ctrl_cfg.svh ***
`ifndef SRAM_CTRL_CFG_SVH
`define SRAM_CTRL_CFG_SVH

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define CLK_PERIOD_NS        10

// ------------------------------------------------------------
// Pin timing, slow grade (worst case of the two grades)
// ------------------------------------------------------------
`define MIN_CYCLE_TIME_NS    35
`define ADDR_TO_END_NS       30
`define STROBE_WIDTH_NS      30
`define ACCESS_TIME_NS       35
`define SELECT_OFF_FLOAT_NS  15
`define STROBE_LOW_FLOAT_NS  15

// Least times round up, at least one cycle
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? \
  1 : (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define CYCLE_CYC            `CYC_UP(`MIN_CYCLE_TIME_NS)
`define STROBE_CYC           `CYC_UP(`STROBE_WIDTH_NS)
`define ADDR_END_CYC         `CYC_UP(`ADDR_TO_END_NS)
`define ACCESS_CYC           `CYC_UP(`ACCESS_TIME_NS)
`define FLOAT_CYC            `CYC_UP(`SELECT_OFF_FLOAT_NS)
`define STROBE_FLOAT_CYC     `CYC_UP(`STROBE_LOW_FLOAT_NS)

// ------------------------------------------------------------
// Organisation
// ------------------------------------------------------------
`define WORD_COUNT           4096
`define ADDR_BITS            12
`define DATA_BITS            4

`endif

// *** include/sram_ctrl_pkg.sv ***
package sram_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WR_FLOAT,
    ST_WR_STROBE,
    ST_WR_TAIL,
    ST_TURN
  } ctrl_state_t;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/1ns

module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and control
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // ----------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // pin_sync

// *** tb/sram_model.sv ***
`timescale 1ns/1ns

// ------------------------------------------------------------
// Behavioural memory on the far side of the pins
// ------------------------------------------------------------
module sram_model #(
  parameter int ACC = 20
) (
  input  wire logic [11:0] word_index_i,
  input  wire logic        select_n_i,
  input  wire logic        write_n_i,
  input  wire logic [3:0]  pins_i,
  output logic      [3:0]  data_o,
  output logic             drive_o
);
  logic [3:0] mem [4096];
  logic       rd_en;

  assign rd_en = !select_n_i && write_n_i;
  // Turn-off is faster than turn-on so two parts never overlap
  assign #(10, 5) drive_o = rd_en;
  // Inertial delay keeps old data well past an index change
  assign #(ACC) data_o = mem[word_index_i];

  always @* begin
    if (!select_n_i && !write_n_i)
      mem[word_index_i] = pins_i;
  end
endmodule // sram_model

// *** tb/sram_ctrl_checker.sv ***
`timescale 1ns/1ns

module sram_ctrl_checker #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 4
) (
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire logic              ce_i,
  input wire logic              req_valid_i,
  input wire logic              req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic              req_ready_o,
  input wire logic              rd_valid_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic [ADDR_W-1:0] word_index_o,
  input wire logic              select_n_o,
  input wire logic              write_n_o,
  input wire logic [DATA_W-1:0] shared_data_pins_i,
  input wire logic [DATA_W-1:0] shared_data_pins_o,
  input wire logic              shared_data_pins_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_read_strobe_high:
    assert property (!select_n_o && $past(!select_n_o) && $past(write_n_o)
      |-> write_n_o) else $error("strobe fell in read");
  a_write_data_held:
    assert property ($rose(write_n_o) |-> $past(!shared_data_pins_oe_n_o))
      else $error("write ended without data");
  a_data_steady:
    assert property (!write_n_o && !shared_data_pins_oe_n_o
      |=> $stable(shared_data_pins_o)) else $error("data moved in write");
  a_read_cycle_len:
    assert property ($fell(select_n_o) && write_n_o
      |=> (!select_n_o && $stable(word_index_o))[*3])
      else $error("read cycle short");
  a_write_cycle_len:
    assert property ($fell(select_n_o) && !write_n_o
      |=> (!select_n_o && $stable(word_index_o))[*4])
      else $error("write cycle short");
  a_addr_before_end:
    assert property ($rose(write_n_o) |-> word_index_o == $past(word_index_o, 3))
      else $error("index moved before write end");
  a_select_width:
    assert property ($rose(select_n_o) && $past(!write_n_o)
      |-> $past(!select_n_o, 3)) else $error("select pulse short");
  a_drive_after_float:
    assert property ($fell(shared_data_pins_oe_n_o)
      |-> !write_n_o && $past(!write_n_o, 2)) else $error("drive too early");
  a_no_drive_read:
    assert property (!select_n_o && write_n_o |-> shared_data_pins_oe_n_o)
      else $error("host drives in read");

  cover property ($rose(rd_valid_o));
  cover property ($rose(write_n_o));
  cover property (!ce_i && !select_n_o);
endmodule // sram_ctrl_checker

bind sram_ctrl sram_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  i_sram_ctrl_checker (.*);

// *** tb/test_sram_ctrl.sv ***
`timescale 1ns/1ns

module test_sram_ctrl;
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        ce_i       = 1'b1;
  logic        valid      = 1'b0;
  logic        wr         = 1'b0;
  logic [11:0] addr       = 12'h000;
  logic [3:0]  wdata      = 4'h0;
  logic [3:0]  last       = 4'h5;
  logic        ready, rdv, sel_n, wr_n, oe_n, drv;
  logic [3:0]  rdata, host, mdata, pins, q;
  logic [11:0] idx;
  int          errors     = 0;
  int          n_checks   = 0;

  always #5 core_clk_i = ~core_clk_i;
  // Released pins show a changing pattern, never a stale value
  always @(posedge core_clk_i) last <= pins;
  assign pins = (oe_n === 1'b0) ? host : (drv === 1'b1) ? mdata : ~last;

  sram_ctrl i_sram_ctrl (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .req_valid_i(valid), .req_write_i(wr),
    .req_addr_i(addr), .req_wdata_i(wdata), .req_ready_o(ready),
    .rd_valid_o(rdv), .rd_data_o(rdata), .word_index_o(idx),
    .select_n_o(sel_n), .write_n_o(wr_n), .shared_data_pins_i(pins),
    .shared_data_pins_o(host), .shared_data_pins_oe_n_o(oe_n));
  sram_model #(.ACC(35)) i_sram_model (.word_index_i(idx),
    .select_n_i(sel_n), .write_n_i(wr_n), .pins_i(pins),
    .data_o(mdata), .drive_o(drv));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input logic w, input logic [11:0] a,
                       input logic [3:0] d);
    int n = 0;
    @(negedge core_clk_i);
    while (ready !== 1'b1 && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(ready, 16'h0001);
    {valid, wr, addr, wdata} = {1'b1, w, a, d};
    @(negedge core_clk_i) valid = 1'b0;
  endtask

  task automatic wait_rd();
    for (int n = 0; n < 20 && rdv !== 1'b1; n++) @(negedge core_clk_i);
    q = (rdv === 1'b1) ? rdata : 4'hX;
  endtask

  task automatic op(input logic w, input logic [11:0] a,
                    input logic [3:0] d);
    issue(w, a, d);
    if (!w)
      wait_rd();
  endtask

  task automatic t_reset();
    chk({ready, sel_n, wr_n, oe_n, rdv}, 16'h001E);
    chk(idx, 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_rw();
    logic [11:0] a [4] = '{12'h000, 12'hFFF, 12'h5A5, 12'hA5A};
    for (int i = 0; i < 4; i++) op(1'b1, a[i], a[i][3:0] ^ 4'h3);
    for (int i = 0; i < 4; i++) begin
      op(1'b0, a[i], 4'h0);
      chk(q, a[i][3:0] ^ 4'h3);
    end
    $display("t_rw done");
  endtask

  task automatic t_refuse();
    op(1'b1, 12'h124, 4'h3);
    op(1'b1, 12'h123, 4'h6);
    @(negedge core_clk_i);
    chk(ready, 16'h0000);
    {valid, wr, addr, wdata} = {1'b1, 1'b1, 12'h124, 4'hE};
    @(negedge core_clk_i) valid = 1'b0;
    op(1'b0, 12'h124, 4'h0);
    chk(q, 4'h3);
    op(1'b0, 12'h123, 4'h0);
    chk(q, 4'h6);
    $display("t_refuse done");
  endtask

  task automatic t_stall();
    issue(1'b0, 12'hFFF, 4'h0);
    repeat (3) @(negedge core_clk_i);
    ce_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    ce_i = 1'b1;
    wait_rd();
    chk(q, 4'hC);
    $display("t_stall done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Host and memory must never drive the pins together
  always @(negedge core_clk_i) begin
    if (rstn_i === 1'b1 && oe_n === 1'b0 && drv !== 1'b0)
      chk(16'h0001, 16'h0000);
  end

  initial begin
    #100000;
    errors++;
    finish_test();
  end

  initial begin
    repeat (16) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_reset();
    t_rw();
    t_refuse();
    t_stall();
    finish_test();
  end
endmodule // test_sram_ctrl
